// ### bench/amh_host_model.sv
/* Host side model: packet sink that can stall the sender.
   Assumes one packet per one-cycle send pulse, sampled on clk_i. */
`timescale 1ns/100ps
module amh_host_model (
   input  wire        clk_i,
   input  wire        pkt_send_i,
   input  wire [2:0]  pkt_kind_i,
   input  wire [15:0] word_i,
   input  wire [3:0]  stall_i,
   output wire        pkt_busy_o,
   output wire [15:0] pkt_n_o,
   output wire [15:0] word_o,
   output wire [2:0]  kind_o
);
   logic [15:0] n_reg = 16'h0;
   logic [15:0] word_reg = 16'h0;
   logic [2:0]  kind_reg = 3'h0;
   logic [3:0]  left_reg = 4'h0;
   // A slow host stays busy for stall_i cycles after each packet
   always @(posedge clk_i) begin
      if (pkt_send_i) begin
         n_reg <= n_reg + 16'h1;
         word_reg <= word_i;
         kind_reg <= pkt_kind_i;
         left_reg <= stall_i;
      end else if (left_reg != 4'h0)
         left_reg <= left_reg - 4'h1;
   end
   assign pkt_busy_o = left_reg != 4'h0;
   assign pkt_n_o = n_reg;
   assign word_o = word_reg;
   assign kind_o = kind_reg;
endmodule

// ### bench/amh_mh_checker.sv
/* Port checker for the mode and health block.
   Assumes one clock, a synchronous active-high reset and the notes' timing. */
`timescale 1ns/100ps
module amh_mh_checker #(
   parameter RATE_W = 16
) (
   input wire              clk_i,
   input wire              sys_rst_i,
   input wire              cfg_load_i,
   input wire [1:0]        cfg_gyro_lpf_i,
   input wire [1:0]        cfg_accel_xy_lpf_i,
   input wire [1:0]        cfg_accel_z_lpf_i,
   input wire [RATE_W-1:0] cfg_turn_thresh_i,
   input wire              fetch_packet_cmd_i,
   input wire              algo_reset_cmd_i,
   input wire [RATE_W-1:0] rate_x_abs_i,
   input wire [RATE_W-1:0] rate_y_abs_i,
   input wire [RATE_W-1:0] rate_z_abs_i,
   input wire [RATE_W-1:0] rate_max_i,
   input wire [RATE_W-1:0] lp_rate_x_abs_i,
   input wire [RATE_W-1:0] lp_rate_y_abs_i,
   input wire [RATE_W-1:0] lp_rate_z_abs_i,
   input wire              pkt_busy_i,
   input wire              pkt_send_o,
   input wire [2:0]        pkt_kind_o,
   input wire [15:0]       health_status_word_o,
   input wire [1:0]        gyro_lpf_o,
   input wire [1:0]        accel_xy_lpf_o,
   input wire [1:0]        accel_z_lpf_o,
   input wire              high_gain_o,
   input wire              low_accel_gain_o,
   input wire              algo_restart_o,
   input wire              fatal_fail_flag_o,
   input wire              rate_overflow_flag_o
);
   reg  [RATE_W-1:0] thr_reg;
   wire              ovr = rate_x_abs_i > rate_max_i || rate_y_abs_i > rate_max_i ||
                           rate_z_abs_i > rate_max_i;
   wire              calm = !ovr && lp_rate_x_abs_i < 16'h001e &&
                            lp_rate_y_abs_i < 16'h001e && lp_rate_z_abs_i < 16'h001e;
   // Shadow of the loaded threshold, so no internal probe is needed
   always @(posedge clk_i) begin
      if (sys_rst_i)
         thr_reg <= 16'h0064;
      else if (cfg_load_i)
         thr_reg <= cfg_turn_thresh_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   rsv_zero_a: assert property (health_status_word_o[7:4] == 4'h0 &&
      health_status_word_o[15:13] == 3'h0) else $error("reserved word bits set");
   summary_or_a: assert property (health_status_word_o[8] ==
      |health_status_word_o[12:9]) else $error("summary bit wrong");
   busy_hold_a: assert property (pkt_busy_i |=> !pkt_send_o)
      else $error("packet sent while busy");
   fetch_send_a: assert property (fetch_packet_cmd_i ##1 !pkt_busy_i |-> ##[0:2] pkt_send_o)
      else $error("fetch gave no packet");
   lpf_load_a: assert property (cfg_load_i |=> gyro_lpf_o == $past(cfg_gyro_lpf_i) &&
      accel_xy_lpf_o == $past(cfg_accel_xy_lpf_i) && accel_z_lpf_o == $past(cfg_accel_z_lpf_i))
      else $error("filter setting not taken");
   rst_dflt_a: assert property ($fell(sys_rst_i) |-> gyro_lpf_o == 2'h2 &&
      accel_xy_lpf_o == 2'h0 && accel_z_lpf_o == 2'h0 && high_gain_o && !pkt_send_o)
      else $error("wrong state after reset");
   ovr_flag_a: assert property (1'b1 |=> rate_overflow_flag_o == $past(ovr))
      else $error("over-range flag wrong");
   restart_hg_a: assert property (algo_restart_o |=> !algo_restart_o && high_gain_o)
      else $error("restart not a pulse into high gain");
   reset_cmd_a: assert property (algo_reset_cmd_i && !fatal_fail_flag_o |->
      ##[0:2] algo_restart_o) else $error("reset command ignored");
   fatal_exit_a: assert property (fatal_fail_flag_o && calm |-> ##[1:3] !fatal_fail_flag_o)
      else $error("fatal hold kept when calm");
   exit_init_a: assert property ($fell(fatal_fail_flag_o) |-> ##[0:1] high_gain_o)
      else $error("no restart after fatal hold");
   turn_gain_a: assert property (low_accel_gain_o |->
      $past(lp_rate_z_abs_i) > $past(thr_reg)) else $error("gain cut below threshold");
   diag_c: cover property (pkt_send_o && pkt_kind_o == 3'h4);
   fatal_c: cover property ($fell(fatal_fail_flag_o));
   turn_c: cover property (low_accel_gain_o);
   restart_c: cover property (algo_restart_o ##1 high_gain_o);
endmodule

bind amh_mode_health amh_mh_checker #(.RATE_W(RATE_W)) amh_mh_checker_i (.*);

// ### bench/testbench.sv
/* Self-checking bench for the mode and health block with a host model.
   Assumes shortened seconds: 100 cycles each, 2 s limits. */
`timescale 1ns/100ps
module testbench;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, cfg_load_i = 1'b0;
   logic [2:0]  cfg_pkt_type_i = 3'h0, cfg_pkt_rate_i = 3'h3;
   logic [1:0]  cfg_gyro_lpf_i = 2'h2, cfg_accel_xy_lpf_i = 2'h0, cfg_accel_z_lpf_i = 2'h0;
   logic        cfg_free_integrate_i = 1'b0, cfg_restart_on_overflow_i = 1'b0;
   logic        cfg_dynamic_motion_i = 1'b1, cfg_turn_alert_i = 1'b0;
   logic [15:0] cfg_turn_thresh_i = 16'h0064, rate_max_i = 16'h07d0;
   logic [3:0]  cfg_cat_enable_i = 4'he, stall = 4'h0;
   logic        fetch_packet_cmd_i = 1'b0, fetch_diag_i = 1'b0, algo_reset_cmd_i = 1'b0;
   logic        hw_fault_i = 1'b0, link_fault_i = 1'b0, sw_fault_i = 1'b0;
   logic        hw_alert_i = 1'b0, gps_missing_i = 1'b0;
   logic [15:0] raw [3] = '{3{16'h0}};
   logic [15:0] lp [3] = '{3{16'h0}};
   wire  [15:0] rate_x_abs_i = raw[0], rate_y_abs_i = raw[1], rate_z_abs_i = raw[2];
   wire  [15:0] lp_rate_x_abs_i = lp[0], lp_rate_y_abs_i = lp[1], lp_rate_z_abs_i = lp[2];
   wire         pkt_send_o, rate_only_o, high_gain_o, low_accel_gain_o, algo_restart_o;
   wire         fatal_fail_flag_o, rate_overflow_flag_o, pkt_busy_i;
   wire  [2:0]  pkt_kind_o, last_kind;
   wire  [15:0] health_status_word_o, pkt_n, last_word;
   wire  [1:0]  gyro_lpf_o, accel_xy_lpf_o, accel_z_lpf_o;
   int          mismatches = 0, check_count = 0, cycles = 0, i;
   logic [15:0] base;

   amh_mode_health #(
      .SEC_TICKS  (100),
      .FREE_LIMIT (2),
      .INIT_TIME  (2)
   ) amh_mode_health_i (.*);

   amh_host_model amh_host_model_i (
      .clk_i      (clk_i),
      .pkt_send_i (pkt_send_o),
      .pkt_kind_i (pkt_kind_o),
      .word_i     (health_status_word_o),
      .stall_i    (stall),
      .pkt_busy_o (pkt_busy_i),
      .pkt_n_o    (pkt_n),
      .word_o     (last_word),
      .kind_o     (last_kind)
   );

   task automatic end_sim();
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic load();
      cfg_load_i = 1'b1;
      tk(1);
      cfg_load_i = 1'b0;
   endtask

   task automatic fget(input logic d, input logic [15:0] exp);
      fetch_diag_i = d;
      fetch_packet_cmd_i = 1'b1;
      tk(1);
      fetch_packet_cmd_i = 1'b0;
      fetch_diag_i = 1'b0;
      tk(4);
      chk(last_word, exp);
   endtask

   always #5 clk_i = ~clk_i;

   // Whole run needs about 1050 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end

   initial begin
      tk(5);
      sys_rst_i = 1'b0;
      tk(1);
      chk({gyro_lpf_o, accel_xy_lpf_o, accel_z_lpf_o, high_gain_o}, 16'h0041);
      base = pkt_n;
      tk(43); // Ten 4-cycle periods plus the three-cycle path to the count
      chk(pkt_n - base, 16'h000a);
      chk(last_kind, 3'h0);
      chk(last_word, 16'h0900);
      cfg_pkt_rate_i = 3'h1;
      stall = 4'h3;
      for (i = 0; i < 5; i++) begin
         cfg_pkt_type_i = (i == 4) ? 3'h5 : i[2:0];
         cfg_gyro_lpf_i = i[1:0];
         cfg_accel_xy_lpf_i = ~i[1:0];
         cfg_accel_z_lpf_i = i[1:0] + 2'h1;
         load();
         tk(12);
         chk(last_kind, (i == 4) ? 3'h3 : i[2:0]);
         chk({gyro_lpf_o, accel_xy_lpf_o, accel_z_lpf_o}, {i[1:0], ~i[1:0], i[1:0] + 2'h1});
      end
      cfg_pkt_rate_i = 3'h0;
      cfg_pkt_type_i = 3'h1;
      stall = 4'h0;
      load();
      tk(4);
      base = pkt_n;
      tk(30);
      chk(pkt_n - base, 16'h0);
      fget(1'b0, 16'h0900);
      chk(last_kind, 3'h1);
      fget(1'b1, 16'h0900);
      chk(last_kind, 3'h4);
      tk(80);
      fget(1'b0, 16'h0000);
      {hw_fault_i, link_fault_i, sw_fault_i, hw_alert_i, gps_missing_i} = 5'h1f;
      fget(1'b0, 16'h050e);
      for (i = 0; i < 2; i++) begin
         cfg_cat_enable_i = i ? 4'h6 : 4'hf;
         load();
         fget(1'b0, i ? 16'h000e : 16'h070e);
      end
      {hw_fault_i, link_fault_i, sw_fault_i, hw_alert_i, gps_missing_i} = 5'h0;
      cfg_cat_enable_i = 4'he;
      load();
      for (i = 0; i < 3; i++) begin
         raw[i] = 16'h07d1;
         tk(2);
         chk({fatal_fail_flag_o, rate_overflow_flag_o}, 16'h1);
         fget(1'b0, 16'h1100);
         raw[i] = 16'h07d0;
         tk(2);
         chk(rate_overflow_flag_o, 1'b0);
      end
      cfg_restart_on_overflow_i = 1'b1;
      load();
      lp = '{3{16'h00c8}};
      raw[1] = 16'h07d1;
      tk(3);
      raw[1] = 16'h0;
      algo_reset_cmd_i = 1'b1;
      tk(1);
      algo_reset_cmd_i = 1'b0;
      lp = '{16'h001e, 16'h001d, 16'h001d};
      tk(5);
      chk(fatal_fail_flag_o, 1'b1);
      lp[0] = 16'h001d;
      tk(5);
      chk({fatal_fail_flag_o, high_gain_o}, 16'h1);
      cfg_restart_on_overflow_i = 1'b0;
      lp = '{3{16'h0}};
      load();
      tk(210);
      chk(high_gain_o, 1'b0);
      for (i = 0; i < 2; i++) begin
         cfg_dynamic_motion_i = i[0];
         load();
         tk(2);
         chk(high_gain_o, !i);
      end
      cfg_turn_thresh_i = 16'h0032;
      cfg_turn_alert_i = 1'b1;
      load();
      for (i = 0; i < 2; i++) begin
         lp[2] = 16'h0033 - i[15:0];
         tk(3);
         chk(low_accel_gain_o, !i);
         fget(1'b0, i ? 16'h0000 : 16'h0900);
      end
      lp[2] = 16'h0;
      for (i = 0; i < 2; i++) begin
         cfg_free_integrate_i = 1'b1;
         load();
         tk(2);
         chk(rate_only_o, 1'b1);
         tk(i ? 230 : 50);
         cfg_free_integrate_i = 1'b0;
         load();
         tk(3);
         chk({rate_only_o, high_gain_o}, i[15:0]);
      end
      tk(210);
      chk(high_gain_o, 1'b0);
      algo_reset_cmd_i = 1'b1;
      tk(1);
      algo_reset_cmd_i = 1'b0;
      tk(3);
      chk(high_gain_o, 1'b1);
      end_sim();
   end
endmodule

// ### rtl/amh_mode_health.v
/*
 * Mode control and built-in-test word for an attitude reference unit:
 * packet pacing and polling, filter cutoff settings, rate-only
 * propagation with its timed exit, over-range hold and restart, gain
 * selection, and the 16-bit health word sent with every packet.
 * Assumes settings arrive as plain levels from the command decoder,
 * taken on a one-cycle load strobe, and commands as one-cycle pulses.
 * Assumes rates arrive as unsigned magnitudes in 0.1 deg/s units, the
 * low-passed ones from the sensor filters, with the range limit beside
 * them, all synchronous to clk_i.
 * Assumes the packet sender takes a send pulse whenever busy is low and
 * keeps the kind and word it was handed until it is done.
 * Fault and alert inputs are plain levels from the health monitors.
 * Timers run on whole seconds divided down from clk_i; one seconds
 * count serves both the init phase and the rate-only stay.
 */
// Behaviour
// - Send chosen packet at set rate, default 25 Hz; quiet means only on fetch.
// - Default packet is angle-plus-inertial; scaled and two nav packets selectable.
// - One rate cutoff for all gyros, default 20 Hz; accel default 5 Hz.
// - Separate accel cutoffs: one for X and Y, one for Z.
// - Rate-only mode propagates from gyro alone, no corrections or accel coupling.
// - Leaving rate-only mode before sixty seconds resumes normal gains, no reset.
// - Leaving rate-only mode after sixty seconds forces reset into high gain.
// - Over-range when any one gyro axis exceeds its measurable range.
// - Restart switch off: flag over-range and keep running.
// - Restart switch on: fatal flag until all rates under 3 deg/s, then restart.
// - Algorithm reset enters high-gain state with heavy accel feedback.
// - Dynamic motion defaults on; off selects higher gain state.
// - Yaw rate above turn threshold, default 10 deg/s, reduces accel gains.
// - Every measurement packet carries the two-byte test word.
// - Low byte holds error flags, high byte holds status alerts.
// - Error bits: fatal 0, hardware 1, link 2, software 3; 4-7 reserved.
// - Status bits: summary 8, hw 9, gps 10, algo 11, range 12; rest reserved.
// - Summary status set whenever any enabled alert is asserted.
// - Hardware, software, sensor and comm categories enable individually.
// - Optionally the algo alert bit shows a turn in progress.
// - Fetch command may request diagnostic packet with full subsystem status.
// - Reset command abandons state and re-enters initialisation; ignored in the over-range hold.
// - High-gain initialisation lasts about 60 s and shows on algo alert bit.
`timescale 1ns/100ps
`include "amh_regs.vh"

module amh_mode_health #(
   parameter SEC_TICKS  = `AMH_SEC_TICKS,
   parameter RATE_W     = 16,
   parameter FREE_LIMIT = `AMH_FREE_LIMIT_S,
   parameter INIT_TIME  = `AMH_INIT_TIME_S
) (
   input  wire              clk_i,
   input  wire              sys_rst_i,
   // Settings from the host
   input  wire              cfg_load_i,
   input  wire [2:0]        cfg_pkt_type_i,
   input  wire [2:0]        cfg_pkt_rate_i,
   input  wire [1:0]        cfg_gyro_lpf_i,
   input  wire [1:0]        cfg_accel_xy_lpf_i,
   input  wire [1:0]        cfg_accel_z_lpf_i,
   input  wire              cfg_free_integrate_i,
   input  wire              cfg_restart_on_overflow_i,
   input  wire              cfg_dynamic_motion_i,
   input  wire [RATE_W-1:0] cfg_turn_thresh_i,
   input  wire [3:0]        cfg_cat_enable_i,
   input  wire              cfg_turn_alert_i,
   // Commands
   input  wire              fetch_packet_cmd_i,
   input  wire              fetch_diag_i,
   input  wire              algo_reset_cmd_i,
   // Sensor side
   input  wire [RATE_W-1:0] rate_x_abs_i,
   input  wire [RATE_W-1:0] rate_y_abs_i,
   input  wire [RATE_W-1:0] rate_z_abs_i,
   input  wire [RATE_W-1:0] rate_max_i,
   input  wire [RATE_W-1:0] lp_rate_x_abs_i,
   input  wire [RATE_W-1:0] lp_rate_y_abs_i,
   input  wire [RATE_W-1:0] lp_rate_z_abs_i,
   input  wire              hw_fault_i,
   input  wire              link_fault_i,
   input  wire              sw_fault_i,
   input  wire              hw_alert_i,
   input  wire              gps_missing_i,
   // Packet stream
   input  wire              pkt_busy_i,
   output reg               pkt_send_o,
   output reg  [2:0]        pkt_kind_o,
   output reg  [15:0]       health_status_word_o,
   // Filter and algorithm controls
   output reg  [1:0]        gyro_lpf_o,
   output reg  [1:0]        accel_xy_lpf_o,
   output reg  [1:0]        accel_z_lpf_o,
   output reg               rate_only_o,
   output reg               high_gain_o,
   output reg               low_accel_gain_o,
   output reg               algo_restart_o,
   output reg               fatal_fail_flag_o,
   output reg               rate_overflow_flag_o
);
   localparam ST_INIT = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_FREE = 2'h2;
   localparam ST_HOLD = 2'h3;
   // Second counts cut to the 8-bit timer on purpose; both limits fit
   localparam [7:0] INIT_SECS = INIT_TIME[7:0];
   localparam [7:0] FREE_SECS = FREE_LIMIT[7:0];
   localparam [7:0] SEC_MAX   = 8'hff;

   reg  [1:0]        state_reg;
   reg  [1:0]        state_next;
   reg  [2:0]        pkt_type_reg;
   reg  [2:0]        pkt_rate_reg;
   reg               free_req_reg;
   reg               restart_ovf_reg;
   reg               dyn_motion_reg;
   reg  [RATE_W-1:0] turn_thresh_reg;
   reg  [3:0]        cat_en_reg;
   reg               turn_alert_reg;
   reg  [31:0]       sub_cnt_reg;
   reg  [7:0]        sec_cnt_reg;
   reg               pend_reg;
   reg               pend_diag_reg;
   reg               ovf_seen_reg;
   wire              rate_tick;
   wire              sec_tick;
   wire [2:0]        over_axis;
   wire              over_range;
   wire              quasi_static;
   wire              turning;
   wire              algo_alert;
   wire [3:0]        alerts;
   wire [2:0]        next_kind;
   wire [15:0]       word;
   reg               restart_now;

   amh_rate_tick #(
      .SEC_TICKS (SEC_TICKS)
   ) u_rate (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .rate_sel_i (pkt_rate_reg),
      .tick_o     (rate_tick)
   );

   // Settings; defaults match the shipped configuration
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pkt_type_reg    <= `AMH_PKT_ANGLE_IMU;
         pkt_rate_reg    <= `AMH_RATE_25;
         gyro_lpf_o      <= `AMH_LPF_20HZ;
         accel_xy_lpf_o  <= `AMH_LPF_5HZ;
         accel_z_lpf_o   <= `AMH_LPF_5HZ;
         free_req_reg    <= 1'b0;
         restart_ovf_reg <= 1'b0;
         dyn_motion_reg  <= 1'b1;
         turn_thresh_reg <= `AMH_TURN_DEFAULT;
         // Hardware alert category ships disabled
         cat_en_reg      <= `AMH_CAT_DEFAULT;
         turn_alert_reg  <= 1'b0;
      end else if (cfg_load_i) begin
         // Diagnostic packet only on request, never periodic
         if (cfg_pkt_type_i != `AMH_PKT_DIAG && cfg_pkt_type_i <= `AMH_PKT_NAV_B)
            pkt_type_reg <= cfg_pkt_type_i;
         // Rate code 0 stops periodic output; fetches still answer
         pkt_rate_reg    <= cfg_pkt_rate_i;
         gyro_lpf_o      <= cfg_gyro_lpf_i;
         accel_xy_lpf_o  <= cfg_accel_xy_lpf_i;
         accel_z_lpf_o   <= cfg_accel_z_lpf_i;
         free_req_reg    <= cfg_free_integrate_i;
         restart_ovf_reg <= cfg_restart_on_overflow_i;
         dyn_motion_reg  <= cfg_dynamic_motion_i;
         turn_thresh_reg <= cfg_turn_thresh_i;
         cat_en_reg      <= cfg_cat_enable_i;
         turn_alert_reg  <= cfg_turn_alert_i;
      end
   end

   // Per-axis over-range and quasi-static compare
   genvar g;
   wire [RATE_W-1:0] raw_rate [0:2];
   wire [RATE_W-1:0] lp_rate  [0:2];
   wire [2:0]        lp_quiet;
   assign raw_rate[0] = rate_x_abs_i;
   assign raw_rate[1] = rate_y_abs_i;
   assign raw_rate[2] = rate_z_abs_i;
   assign lp_rate[0]  = lp_rate_x_abs_i;
   assign lp_rate[1]  = lp_rate_y_abs_i;
   assign lp_rate[2]  = lp_rate_z_abs_i;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_axis
         // Strict compare: a rate right at the limit is still in range
         assign over_axis[g] = raw_rate[g] > rate_max_i;
         assign lp_quiet[g]  = lp_rate[g] < `AMH_QUIET_RATE;
      end
   endgenerate
   assign over_range   = |over_axis;
   assign quasi_static = &lp_quiet;
   // Low-passed yaw, so vibration does not chatter the gain cut
   assign turning      = lp_rate_z_abs_i > turn_thresh_reg;

   // One-second enable for the init and rate-only timers
   // Whole seconds only: a limit is met to within one second
   assign sec_tick = (sub_cnt_reg + 32'h1 >= SEC_TICKS);
   always @(posedge clk_i) begin
      if (sys_rst_i || sec_tick)
         sub_cnt_reg <= 32'h0;
      else
         sub_cnt_reg <= sub_cnt_reg + 32'h1;
   end

   // Algorithm phase sequencer
   always @* begin
      state_next  = state_reg;
      restart_now = 1'b0;
      case (state_reg)
         ST_INIT: begin
            if (restart_ovf_reg && over_range)
               state_next = ST_HOLD;
            else if (sec_tick && sec_cnt_reg + 8'h1 >= INIT_SECS)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (restart_ovf_reg && over_range)
               state_next = ST_HOLD;
            else if (free_req_reg)
               state_next = ST_FREE;
         end
         ST_FREE: begin
            // Over-range still holds in rate-only mode
            if (restart_ovf_reg && over_range)
               state_next = ST_HOLD;
            else if (!free_req_reg) begin
               if (sec_cnt_reg >= FREE_SECS) begin
                  state_next  = ST_INIT;
                  restart_now = 1'b1;
               end else begin
                  state_next = ST_RUN;
               end
            end
         end
         ST_HOLD: begin
            // Restart only when calm, or it would fall straight back
            if (quasi_static && !over_range) begin
               state_next  = ST_INIT;
               restart_now = 1'b1;
            end
         end
         default: state_next = ST_INIT;
      endcase
      // Not taken in the hold: the hold already ends in a restart
      if (algo_reset_cmd_i && state_reg != ST_HOLD) begin
         state_next  = ST_INIT;
         restart_now = 1'b1;
      end
   end

   // Seconds counter: init phase length or time spent rate-only
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg   <= ST_INIT;
         sec_cnt_reg <= 8'h0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg)
            sec_cnt_reg <= 8'h0;
         // Saturates so a long rate-only stay cannot wrap under the limit
         else if (sec_tick && sec_cnt_reg != SEC_MAX)
            sec_cnt_reg <= sec_cnt_reg + 8'h1;
      end
   end

   // Algorithm controls
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         rate_only_o          <= 1'b0;
         high_gain_o          <= 1'b1;
         low_accel_gain_o     <= 1'b0;
         algo_restart_o       <= 1'b0;
         fatal_fail_flag_o    <= 1'b0;
         rate_overflow_flag_o <= 1'b0;
         ovf_seen_reg         <= 1'b0;
      end else begin
         rate_only_o      <= state_next == ST_FREE;
         // Init phase or dynamic motion off both run at high gain
         high_gain_o      <= state_next == ST_INIT || !dyn_motion_reg;
         // Gain cut only once running; init and rate-only keep their gains
         low_accel_gain_o <= turning && state_next == ST_RUN;
         algo_restart_o   <= restart_now;
         fatal_fail_flag_o <= state_next == ST_HOLD;
         // Without restart the flag follows the condition and running goes on
         rate_overflow_flag_o <= over_range;
         ovf_seen_reg     <= over_range;
      end
   end

   // Health word
   // Turn indication shares the algorithm bit only when enabled
   assign algo_alert = state_reg == ST_INIT || high_gain_o ||
                       (turn_alert_reg && turning);
   assign alerts[0] = hw_alert_i    & cat_en_reg[`AMH_CAT_HW];
   assign alerts[1] = gps_missing_i & cat_en_reg[`AMH_CAT_COM];
   assign alerts[2] = algo_alert    & cat_en_reg[`AMH_CAT_SW];
   assign alerts[3] = ovf_seen_reg  & cat_en_reg[`AMH_CAT_SENSOR];
   // A diagnostic fetch overrides the periodic kind for one packet
   assign next_kind = pend_diag_reg ? `AMH_PKT_DIAG : pkt_type_reg;
   assign word = {3'h0,
                  alerts[3],
                  alerts[2],
                  alerts[1],
                  alerts[0],
                  |alerts[3:0],
                  4'h0,
                  sw_fault_i,
                  link_fault_i,
                  hw_fault_i,
                  fatal_fail_flag_o};

   // Packet request: periodic tick or fetch, held until the sender is free
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pend_reg             <= 1'b0;
         pend_diag_reg        <= 1'b0;
         pkt_send_o           <= 1'b0;
         pkt_kind_o           <= `AMH_PKT_ANGLE_IMU;
         health_status_word_o <= 16'h0000;
      end else begin
         pkt_send_o <= 1'b0;
         if (rate_tick || fetch_packet_cmd_i)
            pend_reg <= 1'b1;
         if (fetch_packet_cmd_i && fetch_diag_i)
            pend_diag_reg <= 1'b1;
         if (pend_reg && !pkt_busy_i) begin
            // A request in the sending cycle re-arms, so none is lost
            pend_reg             <= rate_tick || fetch_packet_cmd_i;
            pend_diag_reg        <= fetch_packet_cmd_i && fetch_diag_i;
            pkt_send_o           <= 1'b1;
            pkt_kind_o           <= next_kind;
            health_status_word_o <= word;
         end
      end
   end
endmodule

// ### rtl/amh_rate_tick.v
/*
 * Packet rate divider: one-cycle enable pulse at the selected output rate.
 * Assumes a 100 MHz clock; quiet code gives no pulse.
 */
`timescale 1ns/100ps
`include "amh_regs.vh"

module amh_rate_tick #(
   parameter SEC_TICKS = `AMH_SEC_TICKS
) (
   input  wire       clk_i,
   input  wire       sys_rst_i,
   input  wire [2:0] rate_sel_i,
   output reg        tick_o
);
   reg [31:0] cnt_reg;
   reg [31:0] limit;

   always @* begin
      case (rate_sel_i)
         `AMH_RATE_100: limit = SEC_TICKS / 100;
         `AMH_RATE_50:  limit = SEC_TICKS / 50;
         `AMH_RATE_25:  limit = SEC_TICKS / 25;
         `AMH_RATE_20:  limit = SEC_TICKS / 20;
         `AMH_RATE_10:  limit = SEC_TICKS / 10;
         `AMH_RATE_5:   limit = SEC_TICKS / 5;
         `AMH_RATE_2:   limit = SEC_TICKS / 2;
         default:       limit = 32'h0;
      endcase
   end

   always @(posedge clk_i) begin
      if (sys_rst_i || limit == 32'h0) begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b0;
      end else if (cnt_reg + 32'h1 >= limit) begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
         tick_o  <= 1'b0;
      end
   end
endmodule

// ### rtl/amh_regs.vh
/*
 * Constants for the attitude mode and health word block: test word bit
 * positions, setting encodings, reset defaults and timing counts.
 * Assumes the including module runs on a 100 MHz clock.
 */
`ifndef AMH_REGS_VH
`define AMH_REGS_VH

`define AMH_CLK_HZ            100000000
// Health word bit positions
`define AMH_BIT_FATAL         0
`define AMH_BIT_HW_FAULT      1
`define AMH_BIT_LINK_FAULT    2
`define AMH_BIT_SW_FAULT      3
`define AMH_BIT_ANY_ALERT     8
`define AMH_BIT_HW_ALERT      9
`define AMH_BIT_GPS_ALERT     10
`define AMH_BIT_ALGO_ALERT    11
`define AMH_BIT_RANGE_ALERT   12
// Packet types
`define AMH_PKT_ANGLE_IMU     3'h0
`define AMH_PKT_SCALED        3'h1
`define AMH_PKT_NAV_A         3'h2
`define AMH_PKT_NAV_B         3'h3
`define AMH_PKT_DIAG          3'h4
// Packet rate codes; quiet means polled only
`define AMH_RATE_QUIET        3'h0
`define AMH_RATE_100          3'h1
`define AMH_RATE_50           3'h2
`define AMH_RATE_25           3'h3
`define AMH_RATE_20           3'h4
`define AMH_RATE_10           3'h5
`define AMH_RATE_5            3'h6
`define AMH_RATE_2            3'h7
// Filter cutoff codes
`define AMH_LPF_5HZ           2'h0
`define AMH_LPF_10HZ          2'h1
`define AMH_LPF_20HZ          2'h2
`define AMH_LPF_50HZ          2'h3
// Status category enable bits
`define AMH_CAT_HW            0
`define AMH_CAT_SW            1
`define AMH_CAT_SENSOR        2
`define AMH_CAT_COM           3
`define AMH_CAT_DEFAULT       4'he
// Turn threshold, 0.1 deg/s units: 10.0 deg/s
`define AMH_TURN_DEFAULT      16'h0064
// Quasi-static limit, 0.1 deg/s units: 3 deg/s
`define AMH_QUIET_RATE        16'h001e
// Times in seconds, and clock cycles per second
`define AMH_FREE_LIMIT_S      60
`define AMH_INIT_TIME_S       60
`define AMH_SEC_TICKS         100000000

`endif
